// File: hdl/tpg_pkg.sv
// Package for the pulse generator: register map, field positions, reset values,
// timing constants and shared types.
// Assumes a 20 MHz reference clock and 32-bit APB register access.
package tpg_pkg;

  // Timing
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned US_NS = 1000;
  // Least time rounds up to whole cycles
  localparam int unsigned US_CYCLES = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MIN_PHASE_NS = 50;
  localparam int unsigned MIN_PHASE_CYCLES = (MIN_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [31:0] US_PER_SEC = 32'h000f_4240;
  localparam logic [31:0] PERCENT_FULL = 32'h0000_0064;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_BASE_PER = 8'h04;
  localparam logic [7:0] OFS_BASE_LEN = 8'h08;
  localparam logic [7:0] OFS_LOCK_PER = 8'h0c;
  localparam logic [7:0] OFS_LOCK_LEN = 8'h10;
  localparam logic [7:0] OFS_CABLE_DLY = 8'h14;
  localparam logic [7:0] OFS_USER_DLY = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  localparam logic [7:0] OFS_REPORT = 8'h20;

  // Control field positions
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_FREQ_TYPE = 1;
  localparam int CTRL_RATIO_TYPE = 2;
  localparam int CTRL_USE_LOCKED = 3;
  localparam int CTRL_LOCK_SIG = 4;
  localparam int CTRL_ALIGN = 5;
  localparam int CTRL_POLARITY = 6;
  localparam int CTRL_HOLD_UTC = 7;
  localparam int CTRL_GRID_LSB = 8;
  localparam int CTRL_W = 11;

  // Status field positions
  localparam int STAT_RUNNING = 0;
  localparam int STAT_LOCKED_SET = 1;
  localparam int STAT_LEVEL = 2;
  localparam int STAT_UTC_WAIT = 3;
  localparam int STAT_IN_GRID_LSB = 4;

  // Reset values
  localparam logic [CTRL_W-1:0] RST_CTRL = 11'h160;
  localparam logic [31:0] RST_PERIOD = 32'h000f_4240;
  localparam logic [31:0] RST_LENGTH = 32'h0001_86a0;
  localparam logic [31:0] RST_DELAY = 32'h0000_0000;

  typedef enum logic [2:0] {
    GRID_UTC = 3'h0,
    GRID_GPS = 3'h1,
    GRID_GLONASS = 3'h2,
    GRID_BEIDOU = 3'h3,
    GRID_GALILEO = 3'h4
  } tpg_grid_t;

  typedef enum logic [1:0] {ST_OFF, ST_UTC_WAIT, ST_RUN} tpg_state_t;

  typedef struct packed {
    tpg_state_t st;
    logic [4:0] us_cnt;
    logic [31:0] phase;
    logic tp;
    logic [31:0] pulse_cnt;
    logic [31:0] report;
    logic [CTRL_W-1:0] ctrl;
    logic [31:0] base_per;
    logic [31:0] base_len;
    logic [31:0] lock_per;
    logic [31:0] lock_len;
    logic [31:0] cable_dly;
    logic [31:0] user_dly;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } tpg_regs_t;

endpackage

// File: hdl/tpg_pulse_gen.sv
// Time pulse generator with APB register access and one pulse output pin.
// Assumes the navigation time engine supplies validity, lock, top-of-second
// and disciplined microsecond ticks synchronous to REF_CLK_I.
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/1ps

module tpg_pulse_gen #(
  parameter logic [31:0] DEF_PERIOD_US = tpg_pkg::RST_PERIOD,
  parameter logic [31:0] DEF_LENGTH_US = tpg_pkg::RST_LENGTH,
  parameter int unsigned US_CYC = tpg_pkg::US_CYCLES
) (
  // Clock and reset
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Time engine
  input wire logic TIME_VALID_I,
  input wire logic GRID_LOCKED_I,
  input wire logic UTC_PARAMS_I,
  input wire logic TOP_OF_SECOND_I,
  input wire logic DISC_US_TICK_I,
  // Pulse output
  output logic TP_O
);
  import tpg_pkg::*;

  // Elaboration guard: tick counter is five bits wide
  if (US_CYC < 1 || US_CYC > 31) begin : g_bad_us_cyc
    $error("US_CYC out of range");
  end
  if (DEF_LENGTH_US > DEF_PERIOD_US) begin : g_bad_default
    $error("Default length above default period");
  end

  tpg_regs_t s_r;
  tpg_regs_t s_nxt;

  logic sel_lock;
  logic [31:0] raw_per;
  logic [31:0] raw_len;
  logic [31:0] eff_per;
  logic [31:0] eff_len;
  logic [63:0] ratio_prod;
  logic signed [33:0] ofs;
  logic [33:0] ofs_mag;
  logic [31:0] ofs_mod;
  logic [31:0] start;
  logic [31:0] rel;
  logic active;
  logic local_tick;
  logic us_tick;
  logic realign;
  logic utc_hold;
  logic lead;
  logic pol;
  logic acc;
  logic mapped;
  logic [31:0] rd_mux;
  logic [2:0] in_grid;
  tpg_grid_t grid;

  ////////////////////////////////////////////////////////////////////////////
  // Derived pulse timing

  always_comb begin
    grid = tpg_grid_t'(s_r.ctrl[CTRL_GRID_LSB +: 3]);
    pol = s_r.ctrl[CTRL_POLARITY];
    sel_lock = s_r.ctrl[CTRL_USE_LOCKED] & TIME_VALID_I;
    raw_per = sel_lock ? s_r.lock_per : s_r.base_per;
    raw_len = sel_lock ? s_r.lock_len : s_r.base_len;
    if (s_r.ctrl[CTRL_FREQ_TYPE]) begin
      eff_per = (raw_per == 32'h0) ? 32'h0 : US_PER_SEC / raw_per;
    end else begin
      eff_per = raw_per;
    end
    ratio_prod = 64'(eff_per) * 64'(raw_len);
    if (s_r.ctrl[CTRL_RATIO_TYPE]) begin
      eff_len = 32'(ratio_prod / 64'(PERCENT_FULL));
    end else begin
      eff_len = raw_len;
    end
    if (eff_len > eff_per) begin
      eff_len = eff_per;
    end
    ofs = 34'(signed'(s_r.user_dly)) - 34'(signed'(s_r.cable_dly));
    ofs_mag = ofs[33] ? 34'(-ofs) : 34'(ofs);
    ofs_mod = (eff_per == 32'h0) ? 32'h0 : 32'(ofs_mag % 34'(eff_per));
    if (ofs[33] && ofs_mod != 32'h0) begin
      start = eff_per - ofs_mod;
    end else begin
      start = ofs_mod;
    end
    rel = (s_r.phase >= start) ? s_r.phase - start : s_r.phase + eff_per - start;
    active = (rel < eff_len);
    in_grid = (grid == GRID_UTC) ? 3'(GRID_GPS) : 3'(grid);
  end

  // Local microsecond tick
  assign local_tick = (s_r.us_cnt == 5'(US_CYC - 1));
  assign us_tick = s_r.ctrl[CTRL_LOCK_SIG] ? DISC_US_TICK_I : local_tick;
  assign realign = s_r.ctrl[CTRL_ALIGN] & GRID_LOCKED_I & TOP_OF_SECOND_I;
  assign utc_hold = (grid == GRID_UTC) & s_r.ctrl[CTRL_HOLD_UTC] & ~UTC_PARAMS_I;
  assign lead = (s_r.st == ST_RUN) & (s_r.phase == start) & (eff_len != 32'h0);

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  assign acc = PSEL_I & PENABLE_I;

  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0;
    case (PADDR_I)
      OFS_CTRL: rd_mux = 32'(s_r.ctrl);
      OFS_BASE_PER: rd_mux = s_r.base_per;
      OFS_BASE_LEN: rd_mux = s_r.base_len;
      OFS_LOCK_PER: rd_mux = s_r.lock_per;
      OFS_LOCK_LEN: rd_mux = s_r.lock_len;
      OFS_CABLE_DLY: rd_mux = s_r.cable_dly;
      OFS_USER_DLY: rd_mux = s_r.user_dly;
      OFS_STATUS: begin
        rd_mux[STAT_RUNNING] = (s_r.st == ST_RUN);
        rd_mux[STAT_LOCKED_SET] = sel_lock;
        rd_mux[STAT_LEVEL] = s_r.tp;
        rd_mux[STAT_UTC_WAIT] = (s_r.st == ST_UTC_WAIT);
        rd_mux[STAT_IN_GRID_LSB +: 3] = in_grid;
      end
      OFS_REPORT: rd_mux = s_r.report;
      default: mapped = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_nxt = s_r;
    // Bus: one wait state, so every output is a flop
    s_nxt.pready = 1'b0;
    if (acc && !s_r.pready) begin
      s_nxt.pready = 1'b1;
      s_nxt.pslverr = ~mapped;
      s_nxt.prdata = PWRITE_I ? 32'h0 : rd_mux;
    end
    if (acc && s_r.pready && PWRITE_I) begin
      case (PADDR_I)
        OFS_CTRL: s_nxt.ctrl = PWDATA_I[CTRL_W-1:0];
        OFS_BASE_PER: s_nxt.base_per = PWDATA_I;
        OFS_BASE_LEN: s_nxt.base_len = PWDATA_I;
        OFS_LOCK_PER: s_nxt.lock_per = PWDATA_I;
        OFS_LOCK_LEN: s_nxt.lock_len = PWDATA_I;
        OFS_CABLE_DLY: s_nxt.cable_dly = PWDATA_I;
        OFS_USER_DLY: s_nxt.user_dly = PWDATA_I;
        default: ;
      endcase
    end

    s_nxt.us_cnt = local_tick ? 5'h00 : s_r.us_cnt + 5'h01;

    case (s_r.st)
      ST_OFF: begin
        if (s_r.ctrl[CTRL_ENABLE] && eff_per != 32'h0) begin
          s_nxt.st = utc_hold ? ST_UTC_WAIT : ST_RUN;
        end
      end
      ST_UTC_WAIT: begin
        if (!s_r.ctrl[CTRL_ENABLE] || eff_per == 32'h0) begin
          s_nxt.st = ST_OFF;
        end else if (!utc_hold) begin
          s_nxt.st = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!s_r.ctrl[CTRL_ENABLE] || eff_per == 32'h0) begin
          s_nxt.st = ST_OFF;
        end else if (utc_hold) begin
          s_nxt.st = ST_UTC_WAIT;
        end
      end
      default: s_nxt.st = ST_OFF;
    endcase

    // phase keeps running, realigns when locked
    if (s_r.st != ST_RUN) begin
      s_nxt.phase = 32'h0;
    end else if (realign) begin
      s_nxt.phase = 32'h0;
    end else if (us_tick) begin
      s_nxt.phase = (s_r.phase >= eff_per - 32'h1) ? 32'h0 : s_r.phase + 32'h1;
    end

    if (s_r.st == ST_RUN && active) begin
      s_nxt.tp = pol;
    end else begin
      s_nxt.tp = ~pol;
    end

    if (lead && us_tick) begin
      s_nxt.pulse_cnt = s_r.pulse_cnt + 32'h1;
    end
    if (TOP_OF_SECOND_I) begin
      s_nxt.report = s_r.pulse_cnt + 32'h1;
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      s_r.st <= ST_OFF;
      s_r.us_cnt <= 5'h00;
      s_r.phase <= 32'h0;
      s_r.tp <= ~RST_CTRL[CTRL_POLARITY];
      s_r.pulse_cnt <= 32'h0;
      s_r.report <= 32'h0;
      s_r.ctrl <= RST_CTRL;
      s_r.base_per <= DEF_PERIOD_US;
      s_r.base_len <= DEF_LENGTH_US;
      s_r.lock_per <= DEF_PERIOD_US;
      s_r.lock_len <= DEF_LENGTH_US;
      s_r.cable_dly <= RST_DELAY;
      s_r.user_dly <= RST_DELAY;
      s_r.pready <= 1'b0;
      s_r.pslverr <= 1'b0;
      s_r.prdata <= 32'h0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign PRDATA_O = s_r.prdata;
  assign PREADY_O = s_r.pready;
  assign PSLVERR_O = s_r.pslverr;
  assign TP_O = s_r.tp;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (RST_I);

  a_off_idle_level: assert property (
    (s_r.st == ST_OFF) |=> (TP_O == ~$past(pol)))
    else $error("Output not idle while off");

  a_enable_stops: assert property (
    (s_r.st == ST_RUN && !s_r.ctrl[CTRL_ENABLE]) |=> (s_r.st == ST_OFF) ##1 (TP_O == ~$past(pol)))
    else $error("Pulse continued after disable");

  a_len_in_period: assert property (
    eff_len <= eff_per)
    else $error("Length above period");

  a_locked_period: assert property (
    (s_r.ctrl[CTRL_USE_LOCKED] && TIME_VALID_I && !s_r.ctrl[CTRL_FREQ_TYPE])
      |-> (eff_per == s_r.lock_per))
    else $error("Locked period not used");

  a_base_period: assert property (
    (!(s_r.ctrl[CTRL_USE_LOCKED] && TIME_VALID_I) && !s_r.ctrl[CTRL_FREQ_TYPE])
      |-> (eff_per == s_r.base_per))
    else $error("Base period not used");

  a_align_second: assert property (
    (s_r.st == ST_RUN && realign && s_nxt.st == ST_RUN) |=> (s_r.phase == 32'h0))
    else $error("Phase not realigned");

  a_rate_unlocked: assert property (
    (s_r.st == ST_RUN && s_nxt.st == ST_RUN && !GRID_LOCKED_I && us_tick
      && s_r.phase < eff_per - 32'h1) |=> (s_r.phase == $past(s_r.phase) + 32'h1))
    else $error("Phase stalled without lock");

  a_disc_tick_hold: assert property (
    (s_r.st == ST_RUN && s_nxt.st == ST_RUN && s_r.ctrl[CTRL_LOCK_SIG]
      && !DISC_US_TICK_I && !realign) |=> (s_r.phase == $past(s_r.phase)))
    else $error("Phase moved without disciplined tick");

  a_lead_polarity: assert property (
    lead |=> (TP_O == $past(pol)))
    else $error("Wrong leading level");

  a_utc_withhold: assert property (
    (s_r.st != ST_OFF && utc_hold && s_r.ctrl[CTRL_ENABLE] && eff_per != 32'h0)
      |=> (s_r.st == ST_UTC_WAIT) ##1 (TP_O == ~$past(pol)))
    else $error("Output not withheld on UTC grid");

  a_report_next: assert property (
    TOP_OF_SECOND_I |=> (s_r.report == $past(s_r.pulse_cnt) + 32'h1))
    else $error("Report not for next pulse");

  a_cable_advance: assert property (
    (s_r.user_dly == 32'h0 && s_r.cable_dly != 32'h0 && s_r.cable_dly < eff_per)
      |-> (start == eff_per - s_r.cable_dly))
    else $error("Cable delay not advancing");

  a_user_retard: assert property (
    (s_r.cable_dly == 32'h0 && s_r.user_dly != 32'h0 && s_r.user_dly < eff_per)
      |-> (start == s_r.user_dly))
    else $error("User delay not retarding");

  a_freq_period: assert property (
    (s_r.ctrl[CTRL_FREQ_TYPE] && raw_per != 32'h0)
      |-> (64'(eff_per) * 64'(raw_per) <= 64'(US_PER_SEC)))
    else $error("Frequency not turned into period");

  a_ratio_len: assert property (
    (s_r.ctrl[CTRL_RATIO_TYPE] && raw_len <= PERCENT_FULL)
      |-> (64'(eff_len) * 64'(PERCENT_FULL) <= 64'(eff_per) * 64'(raw_len)))
    else $error("Ratio not turned into length");

  a_input_grid: assert property (
    (grid == GRID_UTC) |-> (in_grid == 3'h1))
    else $error("UTC input not taken as GPS");

  c_lead_edge: cover property (lead ##1 (TP_O == pol));
  c_locked_switch: cover property (!sel_lock ##1 sel_lock && s_r.st == ST_RUN);
  c_realign: cover property (s_r.st == ST_RUN && realign);
  c_utc_wait: cover property (s_r.st == ST_UTC_WAIT ##1 s_r.st == ST_RUN);
  c_freq_mode: cover property (s_r.st == ST_RUN && s_r.ctrl[CTRL_FREQ_TYPE] && lead);

endmodule

// File: verif/tpg_pulse_gen_tb.sv
// Testbench for the pulse generator: APB access tasks and pulse timing tests.
// Assumes tpg_pkg and the pulse sink are compiled first; shortened microsecond.
`timescale 1ns/1ps
module tpg_pulse_gen_tb;
  import tpg_pkg::*;
  // Short microsecond keeps the run small
  localparam int UC = 4;
  localparam logic [31:0] EN = 32'h1 << CTRL_ENABLE;
  localparam logic [31:0] FRQ = 32'h1 << CTRL_FREQ_TYPE;
  localparam logic [31:0] RAT = 32'h1 << CTRL_RATIO_TYPE;
  localparam logic [31:0] ULK = 32'h1 << CTRL_USE_LOCKED;
  localparam logic [31:0] SIG = 32'h1 << CTRL_LOCK_SIG;
  localparam logic [31:0] ALN = 32'h1 << CTRL_ALIGN;
  localparam logic [31:0] POL = 32'h1 << CTRL_POLARITY;
  localparam logic [31:0] HLD = 32'h1 << CTRL_HOLD_UTC;
  localparam logic [31:0] G1 = 32'h1 << CTRL_GRID_LSB;
  logic clk, rst, psel, pen, pwr, prdy, perr, tp, pol, e;
  logic tv, gl, up, tos, ton, dt;
  logic [7:0] pa;
  logic [31:0] pwd, prd, d, n0, r1, nl, act, per;
  logic [31:0] rv [7] = '{32'h160, 32'h000f_4240, 32'h0001_86a0, 32'h000f_4240,
                          32'h0001_86a0, 32'h0, 32'h0};
  logic [31:0] ud [4] = '{32'h0, 32'hffff_fffd, 32'h0, 32'h3};
  logic [31:0] cd [4] = '{32'h0, 32'h0, 32'h3, 32'h0};
  int st [4] = '{0, 7, 7, 3};
  int n_errors, n_tests, c;

  tpg_pulse_gen #(.US_CYC(UC)) dut (
    .REF_CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(pa), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy), .PSLVERR_O(perr),
    .TIME_VALID_I(tv), .GRID_LOCKED_I(gl), .UTC_PARAMS_I(up), .TOP_OF_SECOND_I(tos),
    .DISC_US_TICK_I(dt), .TP_O(tp)
  );
  tpg_pulse_sink sink (
    .clk_i(clk), .rst_i(rst), .tp_i(tp), .pol_i(pol),
    .n_lead_o(nl), .act_o(act), .per_o(per)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Disciplined tick every second cycle when on
  always @(posedge clk) dt <= ton & ~dt;

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_tests++;
    if (s !== x) begin
      n_errors++;
      $display("mismatch at %0t seen %h expected %h", $time, s, x);
    end
  endtask
  // Request held until ready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= wd;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (prdy !== 1'b1 && k < 50);
    if (k >= 50) n_errors++;
    d = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    xfer(1'b1, a, v);
  endtask
  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h0);
  endtask
  task automatic leads(input int n);
    c = 0;
    n0 = nl;
    while (nl - n0 < n && c < 5000) begin
      @(posedge clk);
      c++;
    end
    if (c >= 5000) n_errors++;
  endtask
  task automatic meas(input int a_us, input int p_us);
    leads(3);
    chk(act, a_us * UC);
    chk(per, p_us * UC);
  endtask
  task automatic quiet();
    // Let a pulse already launched before the change drain out
    repeat (4) @(posedge clk);
    n0 = nl;
    repeat (200) @(posedge clk);
    chk(nl, n0);
  endtask
  task automatic setup(input logic [31:0] ct, input logic [31:0] p, input logic [31:0] l);
    wr(OFS_BASE_PER, p);
    wr(OFS_BASE_LEN, l);
    wr(OFS_CTRL, ct);
  endtask
  task automatic pulse_tos();
    @(posedge clk);
    tos <= 1'b1;
    @(posedge clk);
    tos <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {psel, pen, pwr, tv, gl, up, tos, ton, pa, pwd} = '0;
    pol = 1'b1;
    rst = 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      rd(8'(4 * i));
      chk(d, rv[i]);
    end
    rd(8'h24);
    chk(d, 32'h0);
    chk(32'(e), 32'h1);
    chk(tp, 32'h0);
    $display("test reset done");
    setup(EN | POL | G1, 32'ha, 32'h3);
    meas(3, 10);
    pol <= 1'b0;
    setup(EN | G1, 32'ha, 32'h3);
    meas(3, 10);
    wr(OFS_CTRL, G1);
    quiet();
    chk(tp, 32'h1);
    pol <= 1'b1;
    setup(EN | POL | G1 | RAT, 32'ha, 32'h32);
    meas(5, 10);
    setup(EN | POL | G1 | FRQ, 32'h0001_86a0, 32'h3);
    meas(3, 10);
    $display("test shape done");
    wr(OFS_LOCK_PER, 32'h8);
    wr(OFS_LOCK_LEN, 32'h2);
    setup(EN | POL | G1 | ULK, 32'ha, 32'h3);
    meas(3, 10);
    tv <= 1'b1;
    meas(2, 8);
    rd(OFS_STATUS);
    chk(d[STAT_LOCKED_SET], 32'h1);
    tv <= 1'b0;
    wr(OFS_BASE_LEN, 32'h0);
    quiet();
    chk(tp, 32'h0);
    $display("test locked done");
    setup(EN | POL | G1 | SIG, 32'ha, 32'h3);
    quiet();
    ton <= 1'b1;
    leads(3);
    chk(act, 32'h6);
    chk(per, 32'h14);
    ton <= 1'b0;
    $display("test tick done");
    gl <= 1'b1;
    setup(EN | POL | G1 | ALN, 32'ha, 32'h3);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_USER_DLY, ud[i]);
      wr(OFS_CABLE_DLY, cd[i]);
      leads(2);
      // Move off the pulse so the realign is visible
      repeat (5 * UC) @(posedge clk);
      pulse_tos();
      leads(1);
      chk(c >= st[i] * UC - 2 && c <= st[i] * UC + UC + 4, 32'h1);
    end
    gl <= 1'b0;
    leads(2);
    pulse_tos();
    leads(1);
    chk(c > 4 * UC + 4 && c < 5000, 32'h1);
    $display("test align done");
    setup(EN | POL | G1, 32'ha, 32'h3);
    leads(1);
    pulse_tos();
    rd(OFS_REPORT);
    r1 = d;
    leads(2);
    pulse_tos();
    rd(OFS_REPORT);
    chk(d - r1, 32'h2);
    $display("test report done");
    for (int g = 0; g < 5; g++) begin
      wr(OFS_CTRL, 32'(g) << CTRL_GRID_LSB);
      rd(OFS_STATUS);
      chk(d[STAT_IN_GRID_LSB +: 3], (g == 0) ? 32'h1 : 32'(g));
      rd(OFS_CTRL);
      chk(d, 32'(g) << CTRL_GRID_LSB);
    end
    setup(EN | POL | HLD, 32'ha, 32'h3);
    quiet();
    rd(OFS_STATUS);
    chk(d[STAT_UTC_WAIT], 32'h1);
    up <= 1'b1;
    leads(1);
    chk(c < 500, 32'h1);
    $display("test grid done");
    summarize();
  end

  initial begin
    #3000000;
    n_errors++;
    summarize();
  end
endmodule

// File: verif/tpg_pulse_sink.sv
// Downstream sink model: times the pulses seen on the pulse pin in clock cycles.
// Assumes the generator's clock and a leading-edge level given by the bench.
`timescale 1ns/1ps
module tpg_pulse_sink (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Pin and expected leading level
  input wire logic tp_i,
  input wire logic pol_i,
  // Measurements
  output logic [31:0] n_lead_o,
  output logic [31:0] act_o,
  output logic [31:0] per_o
);
  logic prev_r;
  logic [31:0] cnt_r;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prev_r <= 1'b0;
      cnt_r <= 32'h0;
      n_lead_o <= 32'h0;
      act_o <= 32'h0;
      per_o <= 32'h0;
    end else begin
      prev_r <= tp_i;
      cnt_r <= cnt_r + 32'h1;
      if (tp_i == pol_i && prev_r != pol_i) begin
        per_o <= cnt_r;
        cnt_r <= 32'h1;
        n_lead_o <= n_lead_o + 32'h1;
      end
      if (tp_i != pol_i && prev_r == pol_i) begin
        act_o <= cnt_r;
      end
    end
  end
endmodule
